// ### core/vfs_pkg.sv
// constants, command and request codes for the video field sequencer
package vfs_pkg;

  localparam int VFS_FIELDS    = 8;
  localparam int VFS_FW        = 3;
  localparam int VFS_CW        = 16;
  localparam int VFS_GW        = 48;
  localparam int VFS_ARGW      = 8;
  localparam int VFS_OPW       = 3;
  localparam int VFS_XLIM_LSB  = 32;
  localparam int VFS_YST_LSB   = 16;
  localparam int VFS_XST_LSB   = 0;
  localparam int VFS_AW        = 32;
  localparam int VFS_SELW      = 5;
  localparam int VFS_BUF_DEPTH = 2;

  localparam logic [VFS_GW-1:0] VFS_GEOM_RST  = 48'h0;
  localparam logic [VFS_FW-1:0] VFS_FIELD_RST = 3'h0;
  localparam logic [VFS_FW-1:0] VFS_LINK_RST  = 3'h0;
  localparam logic [VFS_CW-1:0] VFS_CNT_RST   = 16'h0;

  typedef enum logic [VFS_OPW-1:0] {
    VFS_CMD_NOP        = 3'h0,
    VFS_CMD_SHIFT_GEOM = 3'h1,
    VFS_CMD_FIELD_LINK = 3'h2,
    VFS_CMD_FRAME_LINK = 3'h3,
    VFS_CMD_FORCE      = 3'h4,
    VFS_CMD_SYNC       = 3'h5,
    VFS_CMD_CLEAR_DONE = 3'h6,
    VFS_CMD_WAIT_DONE  = 3'h7
  } vfs_cmd_e;

  typedef enum logic [1:0] {
    VFS_REQ_NONE  = 2'h0,
    VFS_REQ_FRAME = 2'h1,
    VFS_REQ_FIELD = 2'h2,
    VFS_REQ_LINE  = 2'h3
  } vfs_req_e;

  typedef enum logic [1:0] {
    VFS_ST_RUN   = 2'b00,
    VFS_ST_SYNC  = 2'b01,
    VFS_ST_WDONE = 2'b10
  } vfs_state_e;

endpackage

// ### core/vfs_video_field_sequencer.sv
// video field sequencer: field descriptors, field chaining, address counters
`timescale 1ns/1ps

// Contract
// R1 - eight fields, each holding its own x and y start values
// R2 - a 3-bit index names the field being scanned now
// R3 - each field stores a next-field link and a next-frame first-field link
// R4 - counters load the field's 16-bit x and y start values on init
// R5 - counter bits pass a configurable crossbar into row and column addresses
// R6 - x steps per pixel; at the x limit it reloads and y increments
// R7 - video request carries frame, field or scanline type; each is acted on
// R8 - new frame: active field takes the current field's next-frame link
// R9 - new field: active field takes the current field's next-field link
// R10 - after field change counters load start values and pixel fifo clears; code does neither on a force command, only on frame or field requests
// R11 - new scanline moves one line of pixels, active field unchanged
// R12 - the controller may raise any request at any moment
// R13 - requests are checked often enough that scanlines beat fifo underrun
// R14 - geometry command shifts 48-bit composite left eight, inserts argument
// R15 - field-link command writes the argument into that field's next link
// R16 - frame-link command writes the argument into that field's frame link
// R17 - force command writes the active field at once, any state; code takes it only in the run state
// R18 - sync command stalls commands until new frame, serving other requests
// R19 - on that frame: clear fifo, set field, load counters, ack, resume
// R20 - clear command clears the sticky end-of-frame flag
// R21 - wait command stalls commands until end-of-frame flag is set
// R22 - every new-frame request sets the flag; it stays until cleared
// R23 - requests are valid strobe, 2-bit type code and acknowledge return
module vfs_video_field_sequencer
  import vfs_pkg::*;
#(
  parameter int ADDR_W = VFS_AW
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // command port
  input  wire logic                     cmd_valid,
  input  wire logic [VFS_OPW-1:0]       cmd_op,
  input  wire logic [VFS_FW-1:0]        cmd_field,
  input  wire logic [VFS_ARGW-1:0]      cmd_arg,
  output logic                          cmd_ready,
  // video controller requests
  input  wire logic                     video_request_valid,
  input  wire logic [1:0]               video_request_type,
  output logic                          video_request_ack,
  // crossbar map, one select per output address bit
  input  wire logic [ADDR_W*VFS_SELW-1:0] xbar_map,
  // pixel address stream toward the memory side
  output logic                          pix_valid,
  input  wire logic                     pix_ready,
  output logic [VFS_CW-1:0]             pix_row,
  output logic [VFS_CW-1:0]             pix_col,
  output logic                          fifo_clear,
  // status
  output logic                          frame_done,
  output logic [VFS_FW-1:0]             active_field_index,
  output logic [VFS_CW-1:0]             x_address_counter,
  output logic [VFS_CW-1:0]             y_address_counter
);

  logic [VFS_GW-1:0]  geom_ff [VFS_FIELDS];
  logic [VFS_FW-1:0]  fld_link_ff [VFS_FIELDS];
  logic [VFS_FW-1:0]  frm_link_ff [VFS_FIELDS];
  logic [VFS_FW-1:0]  field_ff;
  logic [VFS_CW-1:0]  x_ff;
  logic [VFS_CW-1:0]  y_ff;
  logic [VFS_FW-1:0]  sync_fld_ff;
  vfs_state_e         state_ff;
  logic               done_ff;
  logic               busy_ff;
  logic               clr_ff;
  logic               ack_ff;
  logic               v1_ff;
  logic               v2_ff;
  logic               v3_ff;
  logic [1:0]         t1_ff;
  logic [1:0]         t2_ff;
  logic               pend_ff;
  logic [1:0]         ptype_ff;
  logic [ADDR_W-1:0]  buf_ff [VFS_BUF_DEPTH];
  logic               wptr_ff;
  logic               rptr_ff;
  logic [1:0]         cnt_ff;

  // request decode; the second and third sync stages feed the edge detect
  wire req_rise    = v2_ff && !v3_ff;
  wire serve       = pend_ff && (ptype_ff != VFS_REQ_LINE || !busy_ff);
  wire serve_frame = serve && ptype_ff == VFS_REQ_FRAME;
  wire serve_field = serve && ptype_ff == VFS_REQ_FIELD;
  wire serve_line  = serve && ptype_ff == VFS_REQ_LINE;
  wire serve_fs    = serve_frame || serve_field;
  wire in_sync     = state_ff == VFS_ST_SYNC;

  // command decode; a field change in the same cycle holds commands off
  assign cmd_ready = state_ff == VFS_ST_RUN && !serve_fs;
  wire take     = cmd_valid && cmd_ready;
  wire op_geom  = take && cmd_op == VFS_CMD_SHIFT_GEOM;
  wire op_flink = take && cmd_op == VFS_CMD_FIELD_LINK;
  wire op_mlink = take && cmd_op == VFS_CMD_FRAME_LINK;
  wire op_force = take && cmd_op == VFS_CMD_FORCE;
  wire op_sync  = take && cmd_op == VFS_CMD_SYNC;
  wire op_clear = take && cmd_op == VFS_CMD_CLEAR_DONE;
  wire op_wait  = take && cmd_op == VFS_CMD_WAIT_DONE;

  // field selection
  wire [VFS_FW-1:0] frm_next = in_sync ? sync_fld_ff
                                       : frm_link_ff[field_ff]; // [R8] [R19]
  wire [VFS_FW-1:0] nxt_field =
    serve_frame ? frm_next :
    serve_field ? fld_link_ff[field_ff] :                      // [R9]
    op_force    ? cmd_arg[VFS_FW-1:0] : field_ff;              // [R17]
  wire [VFS_GW-1:0] new_geom = geom_ff[nxt_field];
  wire [VFS_GW-1:0] cur_geom = geom_ff[field_ff];
  wire [VFS_CW-1:0] x_start  = cur_geom[VFS_XST_LSB +: VFS_CW];
  wire [VFS_CW-1:0] x_limit  = cur_geom[VFS_XLIM_LSB +: VFS_CW];
  wire at_limit  = x_ff == x_limit;

  // scanline pixel stepping, stalled by the two-entry buffer
  wire buf_in_rdy = cnt_ff != 2'(VFS_BUF_DEPTH);
  wire line_step  = busy_ff && buf_in_rdy && !serve_fs;        // [R13]
  wire pop        = pix_valid && pix_ready;

  wire [VFS_CW-1:0] nxt_x =
    serve_fs  ? new_geom[VFS_XST_LSB +: VFS_CW] :              // [R4] [R10]
    !line_step ? x_ff :
    at_limit  ? x_start : x_ff + 16'h1;                        // [R6]
  wire [VFS_CW-1:0] nxt_y =
    serve_fs ? new_geom[VFS_YST_LSB +: VFS_CW] :               // [R4] [R10]
    (line_step && at_limit) ? y_ff + 16'h1 : y_ff;             // [R6]
  wire nxt_busy = serve_fs ? 1'b0 :
                  serve_line ? 1'b1 :                          // [R11]
                  (line_step && at_limit) ? 1'b0 : busy_ff;
  // a frame request landing with the clear keeps the flag set
  wire nxt_done = serve_frame || (done_ff && !op_clear);       // [R20] [R22]

  vfs_state_e nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      VFS_ST_RUN: begin
        if (op_sync)
          nxt_state = VFS_ST_SYNC;                             // [R18]
        else if (op_wait)
          nxt_state = VFS_ST_WDONE;                            // [R21]
      end
      VFS_ST_SYNC: begin
        if (serve_frame)
          nxt_state = VFS_ST_RUN;                              // [R19]
      end
      VFS_ST_WDONE: begin
        if (done_ff)
          nxt_state = VFS_ST_RUN;                              // [R21]
      end
      default: nxt_state = VFS_ST_RUN;
    endcase
  end

  // crossbar: every address bit picks any bit of {y, x}
  wire [ADDR_W-1:0] xy_bits = {y_ff, x_ff};
  logic [ADDR_W-1:0] xbar_out;
  for (genvar i = 0; i < ADDR_W; i++) begin : g_xbar
    assign xbar_out[i] = xy_bits[xbar_map[i*VFS_SELW +: VFS_SELW]]; // [R5]
  end

  // descriptor storage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int n = 0; n < VFS_FIELDS; n++) begin
        geom_ff[n]     <= VFS_GEOM_RST;
        fld_link_ff[n] <= VFS_LINK_RST;
        frm_link_ff[n] <= VFS_LINK_RST;
      end
    end else begin
      if (op_geom)
        geom_ff[cmd_field] <= {geom_ff[cmd_field][VFS_GW-9:0],
                               cmd_arg};                       // [R14] [R1]
      if (op_flink)
        fld_link_ff[cmd_field] <= cmd_arg[VFS_FW-1:0];         // [R15] [R3]
      if (op_mlink)
        frm_link_ff[cmd_field] <= cmd_arg[VFS_FW-1:0];         // [R16] [R3]
    end
  end

  // field, counters and sequencing state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      field_ff    <= VFS_FIELD_RST;
      x_ff        <= VFS_CNT_RST;
      y_ff        <= VFS_CNT_RST;
      sync_fld_ff <= VFS_FIELD_RST;
      state_ff    <= VFS_ST_RUN;
      done_ff     <= 1'b0;
      busy_ff     <= 1'b0;
      clr_ff      <= 1'b0;
      ack_ff      <= 1'b0;
    end else begin
      field_ff <= nxt_field;                                   // [R2]
      x_ff     <= nxt_x;
      y_ff     <= nxt_y;
      if (op_sync)
        sync_fld_ff <= cmd_arg[VFS_FW-1:0];
      state_ff <= nxt_state;
      done_ff  <= nxt_done;
      busy_ff  <= nxt_busy;
      clr_ff   <= serve_fs;                                    // [R10] [R19]
      ack_ff   <= serve;                                       // [R19] [R23]
    end
  end

  // request synchroniser and pending capture; the controller holds type
  // steady while valid is high, so both travel the same two stages
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      v1_ff    <= 1'b0;
      v2_ff    <= 1'b0;
      v3_ff    <= 1'b0;
      t1_ff    <= 2'h0;
      t2_ff    <= 2'h0;
      pend_ff  <= 1'b0;
      ptype_ff <= 2'h0;
    end else begin
      v1_ff <= video_request_valid;
      v2_ff <= v1_ff;
      v3_ff <= v2_ff;
      t1_ff <= video_request_type;
      t2_ff <= t1_ff;
      if (req_rise) begin
        pend_ff  <= 1'b1;                                      // [R7] [R12]
        ptype_ff <= t2_ff;
      end else if (serve) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // two-entry address buffer; a field change drops stale addresses
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
      wptr_ff   <= 1'b0;
      rptr_ff   <= 1'b0;
      cnt_ff    <= 2'h0;
    end else if (serve_fs) begin
      wptr_ff <= 1'b0;
      rptr_ff <= 1'b0;
      cnt_ff  <= 2'h0;
    end else begin
      if (line_step) begin
        buf_ff[wptr_ff] <= xbar_out;                           // [R11]
        wptr_ff         <= !wptr_ff;
      end
      if (pop)
        rptr_ff <= !rptr_ff;
      cnt_ff <= cnt_ff + 2'(line_step) - 2'(pop);
    end
  end

  assign pix_valid          = cnt_ff != 2'h0;
  assign pix_row            = buf_ff[rptr_ff][ADDR_W-1 -: VFS_CW];
  assign pix_col            = buf_ff[rptr_ff][VFS_CW-1:0];
  assign fifo_clear         = clr_ff;
  assign video_request_ack  = ack_ff;
  assign frame_done         = done_ff;
  assign active_field_index = field_ff;
  assign x_address_counter  = x_ff;
  assign y_address_counter  = y_ff;

  // checks
  wire [VFS_FW-1:0] p_frm = frm_link_ff[field_ff];
  wire [VFS_FW-1:0] p_fld = fld_link_ff[field_ff];

  sequence s_sync_hit;
    in_sync && serve_frame;
  endsequence
  sequence s_sync_done;
    state_ff == VFS_ST_RUN && ack_ff && clr_ff;
  endsequence
  sequence s_sync_wait;
    in_sync && !cmd_ready;
  endsequence
  sequence s_wait_open;
    state_ff == VFS_ST_WDONE && frame_done;
  endsequence

  a_frame_link: assert property (@(posedge clock) disable iff (rst) // [R8]
    serve_frame && !in_sync |=> field_ff == $past(p_frm))
    else $error("frame request did not follow frame link");
  a_field_link: assert property (@(posedge clock) disable iff (rst) // [R9]
    serve_field |=> field_ff == $past(p_fld))
    else $error("field request did not follow field link");
  a_counter_load: assert property (@(posedge clock) disable iff (rst) // [R10]
    serve_fs |=> x_ff == geom_ff[field_ff][VFS_XST_LSB +: VFS_CW]
      && y_ff == geom_ff[field_ff][VFS_YST_LSB +: VFS_CW] && fifo_clear)
    else $error("counters or fifo not reset on field change");
  a_line_wrap: assert property (@(posedge clock) disable iff (rst) // [R6]
    line_step && at_limit |=> x_ff == $past(x_start)
      && y_ff == $past(y_ff) + 16'h1 && !busy_ff)
    else $error("x limit wrap wrong");
  a_line_keep_field: assert property ( // [R11]
    @(posedge clock) disable iff (rst)
    serve_line && !op_force |=> field_ff == $past(field_ff) && busy_ff)
    else $error("scanline request changed field");
  a_geom_shift: assert property (@(posedge clock) disable iff (rst) // [R14]
    op_geom |=> geom_ff[$past(cmd_field)] ==
      {$past(geom_ff[cmd_field][VFS_GW-9:0]), $past(cmd_arg)})
    else $error("geometry shift wrong");
  a_sync_release: assert property (@(posedge clock) disable iff (rst) // [R19]
    s_sync_hit |=> s_sync_done ##0 field_ff == $past(sync_fld_ff))
    else $error("sync release wrong");
  a_sync_stall: assert property (@(posedge clock) disable iff (rst) // [R18]
    op_sync |=> s_sync_wait)
    else $error("commands not stalled in sync wait");
  a_done_sticky: assert property (@(posedge clock) disable iff (rst) // [R22]
    serve_frame |=> frame_done ##1 (frame_done || $past(op_clear)))
    else $error("end-of-frame flag lost");
  a_wait_stall: assert property (@(posedge clock) disable iff (rst) // [R21]
    state_ff == VFS_ST_WDONE && !frame_done |=>
      state_ff == VFS_ST_WDONE && !cmd_ready)
    else $error("command taken while waiting for frame end");
  a_ack_bound: assert property (@(posedge clock) disable iff (rst) // [R23]
    serve |=> video_request_ack)
    else $error("request not acknowledged");

  // sequencing checks on the command side
  a_sync_hold: assert property (@(posedge clock) disable iff (rst) // [R18]
    s_sync_wait ##0 !serve_frame |=> s_sync_wait)
    else $error("sync wait left without a frame request");
  a_sync_capture: assert property (@(posedge clock) disable iff (rst) // [R19]
    op_sync |=> sync_fld_ff == $past(cmd_arg[VFS_FW-1:0]))
    else $error("sync argument not kept");
  a_wait_enter: assert property (@(posedge clock) disable iff (rst) // [R21]
    op_wait |=> state_ff == VFS_ST_WDONE && !cmd_ready)
    else $error("wait command did not stall");
  a_wait_release: assert property (@(posedge clock) disable iff (rst) // [R21]
    s_wait_open |=> state_ff == VFS_ST_RUN)
    else $error("wait not released by end-of-frame flag");
  a_clear_flag: assert property (@(posedge clock) disable iff (rst) // [R20]
    op_clear && !serve_frame |=> !frame_done)
    else $error("end-of-frame flag not cleared");
  a_force_field: assert property (@(posedge clock) disable iff (rst) // [R17]
    op_force |=> active_field_index == $past(cmd_arg[VFS_FW-1:0]))
    else $error("force command did not set field");
  a_link_write: assert property (@(posedge clock) disable iff (rst) // [R15]
    op_flink |=>
      fld_link_ff[$past(cmd_field)] == $past(cmd_arg[VFS_FW-1:0]))
    else $error("field link not written");
  a_frame_write: assert property (@(posedge clock) disable iff (rst) // [R16]
    op_mlink |=>
      frm_link_ff[$past(cmd_field)] == $past(cmd_arg[VFS_FW-1:0]))
    else $error("frame link not written");

  // video side and pixel buffer checks
  a_req_capture: assert property (@(posedge clock) disable iff (rst) // [R7]
    req_rise |=> pend_ff && ptype_ff == $past(t2_ff))
    else $error("request edge not captured");
  a_type0_noop: assert property (@(posedge clock) disable iff (rst) // [R7]
    serve && ptype_ff == VFS_REQ_NONE && !op_force |=>
      $stable(active_field_index) && !fifo_clear)
    else $error("empty request changed the field");
  a_fifo_flush: assert property (@(posedge clock) disable iff (rst) // [R10]
    serve_fs |=> !pix_valid && !busy_ff)
    else $error("field change left stale pixel addresses");
  a_x_step: assert property (@(posedge clock) disable iff (rst) // [R6]
    line_step && !at_limit |=>
      x_ff == $past(x_ff) + 16'h1 && $stable(y_ff))
    else $error("x counter did not step by one");
  a_x_hold: assert property (@(posedge clock) disable iff (rst) // [R6]
    !line_step && !serve_fs |=> $stable(x_ff) && $stable(y_ff))
    else $error("counters moved without a pixel");
  // a stalled consumer must see the same word until it takes it or a field change drops it
  a_pix_hold: assert property (@(posedge clock) disable iff (rst) // [R11]
    pix_valid && !pix_ready && !serve_fs |=>
      pix_valid && $stable(pix_row) && $stable(pix_col))
    else $error("stalled pixel address changed");

endmodule

// ### test/vfs_vid_ctrl.sv
// video controller model: raises frame, field and scanline requests
`timescale 1ns/1ps
module vfs_vid_ctrl (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // request handshake
  output logic            video_request_valid,
  output logic [1:0]      video_request_type,
  input  wire logic       video_request_ack
);
  initial begin
    video_request_valid = 1'b0;
    video_request_type  = 2'h0;
  end
  // hold until ack, then idle 3 cycles so the next rise is seen
  task automatic send(input logic [1:0] t, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clock);
    // a request raised in reset would read as an edge at release
    video_request_valid <= !rst; // any type at any moment
    video_request_type  <= t;
    for (n = 0; n < 40 && !ok; n++) begin
      @(negedge clock);
      ok = (video_request_ack === 1'b1);
    end
    @(posedge clock);
    video_request_valid <= 1'b0;
    // a stale code must not look like a held request
    video_request_type  <= ~t;
    repeat (3) @(posedge clock);
  endtask
endmodule

// ### test/vfs_video_field_sequencer_bench.sv
// self-checking bench for the video field sequencer
`timescale 1ns/1ps
module vfs_video_field_sequencer_bench;
  import vfs_pkg::*;
  logic          clock, rst, cmd_valid, cmd_ready, pix_valid, pix_ready;
  logic [2:0]    cmd_op, cmd_field, active_field_index;
  logic [7:0]    cmd_arg;
  logic          vr_valid, vr_ack, fifo_clear, frame_done;
  logic [1:0]    vr_type;
  logic [159:0]  xbar_map;
  logic [15:0]   pix_row, pix_col, x_address_counter, y_address_counter;
  int            n_fail, check_count, clr_count;

  vfs_video_field_sequencer i_vfs_video_field_sequencer (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_field(cmd_field), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
    .video_request_valid(vr_valid), .video_request_type(vr_type),
    .video_request_ack(vr_ack), .xbar_map(xbar_map),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_row(pix_row),
    .pix_col(pix_col), .fifo_clear(fifo_clear), .frame_done(frame_done),
    .active_field_index(active_field_index),
    .x_address_counter(x_address_counter),
    .y_address_counter(y_address_counter));
  vfs_vid_ctrl i_vfs_vid_ctrl (
    .clock(clock), .rst(rst), .video_request_valid(vr_valid),
    .video_request_type(vr_type), .video_request_ack(vr_ack));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (fifo_clear === 1'b1) clr_count++;
  end

  task automatic chk(input logic [15:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    $display("MISMATCH at %0t: wait ran out", $time);
    final_report();
  endtask
  task automatic step;
    @(posedge clock);
    @(negedge clock);
  endtask
  // one gap cycle between commands keeps cmd_valid to one write per step
  task automatic cmd(input vfs_cmd_e op, input logic [2:0] f,
                     input logic [7:0] a);
    int n;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_field <= f;
    cmd_arg   <= a;
    for (n = 0; n < 20; n++) begin
      @(negedge clock);
      if (cmd_ready === 1'b1) break;
    end
    if (n == 20) hang();
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask
  task automatic req(input vfs_req_e t);
    bit ok;
    i_vfs_vid_ctrl.send(t, ok);
    if (!ok) hang();
    @(negedge clock);
  endtask
  // composite is {x limit, y start, x start}, top byte goes in first
  task automatic geom(input logic [2:0] f, input logic [47:0] v);
    for (int k = 5; k >= 0; k--) cmd(VFS_CMD_SHIFT_GEOM, f, v[k*8 +: 8]);
  endtask

  task automatic t_config;
    chk(active_field_index, 0, "reset field");
    chk(frame_done, 0, "reset flag");
    geom(0, {16'h0002, 16'h0005, 16'h0000});
    geom(1, {16'h0003, 16'h0a20, 16'h0001});
    cmd(VFS_CMD_FIELD_LINK, 0, 8'h01);
    cmd(VFS_CMD_FRAME_LINK, 1, 8'h00);
    cmd(VFS_CMD_FRAME_LINK, 0, 8'h00);
    $display("test config done");
  endtask
  task automatic t_field;
    int c0;
    c0 = clr_count;
    cmd(VFS_CMD_FORCE, 0, 8'h01);
    step();
    chk(active_field_index, 1, "force 1");
    chk(x_address_counter, 0, "force keeps x");
    cmd(VFS_CMD_FORCE, 0, 8'h00);
    step();
    chk(active_field_index, 0, "force 0");
    req(VFS_REQ_FIELD);
    chk(active_field_index, 1, "field link");
    chk(x_address_counter, 16'h0001, "field x");
    chk(y_address_counter, 16'h0a20, "field y");
    chk(clr_count, c0 + 1, "field clear");
    req(VFS_REQ_FRAME);
    chk(active_field_index, 0, "frame link");
    chk(x_address_counter, 0, "frame x");
    chk(y_address_counter, 16'h0005, "frame y");
    chk(frame_done, 1, "flag set");
    req(VFS_REQ_NONE);
    chk(clr_count, c0 + 2, "type 0 no clear");
    $display("test field done");
  endtask
  task automatic t_line;
    int n;
    @(posedge clock);
    pix_ready <= 1'b0;
    req(VFS_REQ_LINE);
    repeat (8) @(negedge clock);
    chk(pix_valid, 1, "stalled word held");
    @(posedge clock);
    pix_ready <= 1'b1;
    n = 0;
    repeat (30) begin
      @(negedge clock);
      if (pix_valid === 1'b1) begin
        chk(pix_col, n, "column");
        chk(pix_row, 16'h0005, "row");
        n++;
      end
    end
    chk(n, 3, "pixels per line");
    chk(x_address_counter, 0, "x reload");
    chk(y_address_counter, 16'h0006, "y step");
    chk(active_field_index, 0, "line keeps field");
    $display("test line done");
  endtask
  task automatic t_sync;
    int c0;
    cmd(VFS_CMD_CLEAR_DONE, 0, 8'h00);
    step();
    chk(frame_done, 0, "flag clear");
    cmd(VFS_CMD_FRAME_LINK, 1, 8'h01);
    cmd(VFS_CMD_SYNC, 0, 8'h00);
    step();
    chk(cmd_ready, 0, "sync stalls");
    req(VFS_REQ_FIELD);
    chk(active_field_index, 1, "field in sync");
    chk(cmd_ready, 0, "still stalled");
    c0 = clr_count;
    req(VFS_REQ_FRAME);
    chk(active_field_index, 0, "sync field");
    chk(y_address_counter, 16'h0005, "sync y");
    chk(clr_count, c0 + 1, "sync clear");
    chk(cmd_ready, 1, "sync resumes");
    $display("test sync done");
  endtask
  task automatic t_wait;
    cmd(VFS_CMD_CLEAR_DONE, 0, 8'h00);
    cmd(VFS_CMD_WAIT_DONE, 0, 8'h00);
    step();
    chk(cmd_ready, 0, "wait stalls");
    chk(frame_done, 0, "flag stays clear");
    req(VFS_REQ_FIELD);
    chk(active_field_index, 1, "field in wait");
    chk(cmd_ready, 0, "wait held");
    req(VFS_REQ_FRAME);
    chk(frame_done, 1, "flag on frame");
    chk(active_field_index, 1, "frame link 1");
    chk(cmd_ready, 1, "wait released");
    $display("test wait done");
  endtask
  task automatic t_abort;
    @(posedge clock);
    pix_ready <= 1'b0;
    req(VFS_REQ_LINE);
    chk(pix_valid, 1, "line under way");
    req(VFS_REQ_FIELD);
    chk(pix_valid, 0, "field drops words");
    chk(active_field_index, 0, "mid-line field");
    chk(y_address_counter, 16'h0005, "mid-line y");
    @(posedge clock);
    pix_ready <= 1'b1;
    repeat (10) @(negedge clock);
    chk(pix_valid, 0, "aborted line stays stopped");
    $display("test abort done");
  endtask

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_field = 3'h0;
    cmd_arg = 8'h00;
    pix_ready = 1'b1;
    n_fail = 0;
    check_count = 0;
    clr_count = 0;
    // identity map: row is y, column is x
    for (int i = 0; i < 32; i++) xbar_map[i*5 +: 5] = i[4:0];
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    t_config();
    t_field();
    t_line();
    t_sync();
    t_wait();
    t_abort();
    final_report();
  end
endmodule
